//--- rtl/rscc_regs.svh
// Register offsets, field positions, reset values and timing counts
// for the retry status and card control configuration bytes.
// Assumes byte-wide configuration accesses addressed by byte offset.
`ifndef RSCC_REGS_SVH
`define RSCC_REGS_SVH

// ----------------------------------------------------------------
// Offsets and reset values
// ----------------------------------------------------------------
`define RSCC_RETRY_OFS 8'h90
`define RSCC_CARD_OFS 8'h91
`define RSCC_RETRY_RST 8'hc0
`define RSCC_CARD_RST 8'h00

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define RSCC_HOST_EN_BIT 7
`define RSCC_CARD_EN_BIT 6
`define RSCC_TEXP_B_BIT 5
`define RSCC_TEXP_A_BIT 3
`define RSCC_TEXP_H_BIT 1
`define RSCC_RING_BIT 7
`define RSCC_VIDEO_BIT 6
`define RSCC_RSVD5_BIT 5
`define RSCC_AUDIO_BIT 2
`define RSCC_CARD_SPEAKER_IN_BIT 1
`define RSCC_IRQ_BIT 0

// ----------------------------------------------------------------
// Timing: retry timeout is two to the fifteenth clock cycles
// ----------------------------------------------------------------
`define RSCC_RETRY_LOG2 15
`define RSCC_RETRY_CYCLES 32768

`endif

//--- rtl/rscc_pkg.sv
// Types shared by the retry status and card control register block.
// Assumes the constants header supplies the numeric values.
package rscc_pkg;

    // Configuration byte access from the host bus front end
    typedef struct packed {
        logic       rd;
        logic       wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } rscc_cfg_s;

    // Retry events of one counter channel
    typedef struct packed {
        logic start;
        logic done;
    } rscc_retry_s;

    // Retry watchdog states
    typedef enum logic [1:0] {
        RSCC_IDLE = 2'b01,
        RSCC_RUN  = 2'b10
    } rscc_state_e;

endpackage

//--- rtl/rscc_retry_timer.sv
// One retry timeout watchdog channel.
// Assumes start and done are one-cycle pulses in the clock domain.
`timescale 1ns/1ps

module rscc_retry_timer
    import rscc_pkg::*;
#(
    parameter int CNT_W = 15
) (
    // Clock and reset
    input wire logic clock_i,
    input wire logic rst_i,
    // Control
    input wire logic enable_i,
    input rscc_retry_s ev_i,
    // Result
    output logic expire_o
);

    // ----------------------------------------------------------------
    // Watchdog state and counter
    // ----------------------------------------------------------------
    rscc_state_e state_q, state_d;
    logic [CNT_W-1:0] cnt_q, cnt_d;
    logic expire_q, expire_d;

    // Count from a retry until the master returns or time runs out
    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        expire_d = 1'b0;
        case (state_q)
            RSCC_IDLE: begin
                cnt_d = '0;
                if (enable_i && ev_i.start && !ev_i.done) begin
                    state_d = RSCC_RUN;
                end
            end
            RSCC_RUN: begin
                // Return or disable resets the watchdog
                if (!enable_i || ev_i.done) begin
                    state_d = RSCC_IDLE;
                    cnt_d = '0;
                end else if (cnt_q == {CNT_W{1'b1}}) begin
                    // Full 2^CNT_W clocks without a return
                    expire_d = 1'b1;
                    state_d = RSCC_IDLE;
                    cnt_d = '0;
                end else begin
                    cnt_d = cnt_q + 1'b1;
                end
            end
            default: begin
                state_d = RSCC_IDLE;
                cnt_d = '0;
            end
        endcase
    end

    // Register stage
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            state_q <= RSCC_IDLE;
            cnt_q <= '0;
            expire_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            expire_q <= expire_d;
        end
    end

    assign expire_o = expire_q;

endmodule

//--- rtl/rscc_top.sv
// Retry status and card control configuration registers of a card bridge.
// Assumes a front end delivering one-cycle byte reads and writes, and
// retry start/return pulses from the host and card target state machines.
// The register image outputs are wired from flops for the rest of the bridge.
`timescale 1ns/1ps
`include "rscc_regs.svh"

module rscc_top
    import rscc_pkg::*;
#(
    parameter int RETRY_LOG2 = `RSCC_RETRY_LOG2
) (
    // Clock and reset
    input wire logic clock_i,
    input wire logic rst_i,
    // Configuration access
    input rscc_cfg_s cfg_i,
    output logic [7:0] cfg_rdata_o,
    output logic cfg_hit_o,
    // Retry events: host target, card target A, card target B
    input rscc_retry_s host_retry_i,
    input rscc_retry_s card_a_retry_i,
    input rscc_retry_s card_b_retry_i,
    // Card signals
    input wire logic card_func_irq_i,
    input wire logic ring_indicate_in_i,
    input wire logic ring_pin_select_i,
    input wire logic card_audio_in_i,
    input wire logic card_speaker_in_i,
    // Routed outputs
    output logic ring_pme_pin_o,
    output logic ring_multi_o,
    output logic audio_pwm_output_o,
    output logic speaker_output_pin_o,
    output logic speaker_output_pin_oe_o,
    output logic video_port_oe_o,
    // Register image for the rest of the bridge
    output logic [7:0] retry_timeout_status_o,
    output logic [7:0] card_control_o
);

    // ----------------------------------------------------------------
    // Register state
    // ----------------------------------------------------------------
    logic host_side_retry_counter_en_q, host_side_retry_counter_en_d;
    logic card_side_retry_counter_en_q, card_side_retry_counter_en_d;
    logic host_target_expired_q, host_target_expired_d;
    logic card_target_a_expired_q, card_target_a_expired_d;
    logic card_target_b_expired_q, card_target_b_expired_d;
    logic ring_output_enable_q, ring_output_enable_d;
    logic video_port_hiz_enable_q, video_port_hiz_enable_d;
    logic card_rsvd5_q, card_rsvd5_d;
    logic card_audio_route_en_q, card_audio_route_en_d;
    logic speaker_route_enable_q, speaker_route_enable_d;
    logic card_func_irq_flag_q, card_func_irq_flag_d;
    logic [7:0] rdata_q, rdata_d;
    logic hit_q, hit_d;
    logic host_exp, card_a_exp, card_b_exp;
    logic wr_retry, wr_card;
    logic [7:0] retry_img, card_img;

    // ----------------------------------------------------------------
    // Retry watchdogs
    // ----------------------------------------------------------------
    // One watchdog per retrying target; an expiry pulse sets its flag
    rscc_retry_timer #(.CNT_W(RETRY_LOG2)) u_host_timer (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .enable_i(host_side_retry_counter_en_q),
        .ev_i(host_retry_i),
        .expire_o(host_exp)
    );

    // Both card channels share the card-side enable
    rscc_retry_timer #(.CNT_W(RETRY_LOG2)) u_card_a_timer (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .enable_i(card_side_retry_counter_en_q),
        .ev_i(card_a_retry_i),
        .expire_o(card_a_exp)
    );

    rscc_retry_timer #(.CNT_W(RETRY_LOG2)) u_card_b_timer (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .enable_i(card_side_retry_counter_en_q),
        .ev_i(card_b_retry_i),
        .expire_o(card_b_exp)
    );

    // ----------------------------------------------------------------
    // Read images and write decode
    // ----------------------------------------------------------------
    // Reserved positions other than the writable card bit 5 are built as constant zeros
    always_comb begin
        retry_img = 8'h00;
        retry_img[`RSCC_HOST_EN_BIT] = host_side_retry_counter_en_q;
        retry_img[`RSCC_CARD_EN_BIT] = card_side_retry_counter_en_q;
        retry_img[`RSCC_TEXP_B_BIT] = card_target_b_expired_q;
        retry_img[`RSCC_TEXP_A_BIT] = card_target_a_expired_q;
        retry_img[`RSCC_TEXP_H_BIT] = host_target_expired_q;
        card_img = 8'h00;
        card_img[`RSCC_RING_BIT] = ring_output_enable_q;
        card_img[`RSCC_VIDEO_BIT] = video_port_hiz_enable_q;
        card_img[`RSCC_RSVD5_BIT] = card_rsvd5_q;
        card_img[`RSCC_AUDIO_BIT] = card_audio_route_en_q;
        card_img[`RSCC_CARD_SPEAKER_IN_BIT] = speaker_route_enable_q;
        card_img[`RSCC_IRQ_BIT] = card_func_irq_flag_q;
    end

    // Write strobes; writes to any other offset are dropped
    assign wr_retry = cfg_i.wr && (cfg_i.addr == `RSCC_RETRY_OFS);
    assign wr_card = cfg_i.wr && (cfg_i.addr == `RSCC_CARD_OFS);

    // ----------------------------------------------------------------
    // Next register values
    // ----------------------------------------------------------------
    // Flags: hardware set is applied after the clear so a coincident event survives
    always_comb begin
        host_side_retry_counter_en_d = host_side_retry_counter_en_q;
        card_side_retry_counter_en_d = card_side_retry_counter_en_q;
        host_target_expired_d = host_target_expired_q;
        card_target_a_expired_d = card_target_a_expired_q;
        card_target_b_expired_d = card_target_b_expired_q;
        ring_output_enable_d = ring_output_enable_q;
        video_port_hiz_enable_d = video_port_hiz_enable_q;
        card_rsvd5_d = card_rsvd5_q;
        card_audio_route_en_d = card_audio_route_en_q;
        speaker_route_enable_d = speaker_route_enable_q;
        card_func_irq_flag_d = card_func_irq_flag_q;
        // Counter enables are plain read/write bits
        if (wr_retry) begin
            host_side_retry_counter_en_d = cfg_i.wdata[`RSCC_HOST_EN_BIT];
            card_side_retry_counter_en_d = cfg_i.wdata[`RSCC_CARD_EN_BIT];
            // Only a one clears; a zero leaves the flag alone
            if (cfg_i.wdata[`RSCC_TEXP_B_BIT]) begin
                card_target_b_expired_d = 1'b0;
            end
            if (cfg_i.wdata[`RSCC_TEXP_A_BIT]) begin
                card_target_a_expired_d = 1'b0;
            end
            if (cfg_i.wdata[`RSCC_TEXP_H_BIT]) begin
                host_target_expired_d = 1'b0;
            end
        end else if (wr_card) begin
            ring_output_enable_d = cfg_i.wdata[`RSCC_RING_BIT];
            video_port_hiz_enable_d = cfg_i.wdata[`RSCC_VIDEO_BIT];
            // Kept writable; software is expected to leave it alone
            card_rsvd5_d = cfg_i.wdata[`RSCC_RSVD5_BIT];
            card_audio_route_en_d = cfg_i.wdata[`RSCC_AUDIO_BIT];
            speaker_route_enable_d = cfg_i.wdata[`RSCC_CARD_SPEAKER_IN_BIT];
            if (cfg_i.wdata[`RSCC_IRQ_BIT]) begin
                card_func_irq_flag_d = 1'b0;
            end
        end
        // Hardware events win over a clear in the same cycle
        if (host_exp) begin
            host_target_expired_d = 1'b1;
        end
        if (card_a_exp) begin
            card_target_a_expired_d = 1'b1;
        end
        if (card_b_exp) begin
            card_target_b_expired_d = 1'b1;
        end
        if (card_func_irq_i) begin
            card_func_irq_flag_d = 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // Read return
    // ----------------------------------------------------------------
    // Read data: registered, one cycle after the request
    always_comb begin
        rdata_d = rdata_q;
        hit_d = 1'b0;
        if (cfg_i.rd && (cfg_i.addr == `RSCC_RETRY_OFS)) begin
            rdata_d = retry_img;
            hit_d = 1'b1;
        end else if (cfg_i.rd && (cfg_i.addr == `RSCC_CARD_OFS)) begin
            rdata_d = card_img;
            hit_d = 1'b1;
        end else if (cfg_i.rd) begin
            // No hit, so another function of the bridge may claim the access
            rdata_d = 8'h00;
        end
    end

    // ----------------------------------------------------------------
    // Register stage
    // ----------------------------------------------------------------

    // Register stage for the control and status bits
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            host_side_retry_counter_en_q <= 1'b1;
            card_side_retry_counter_en_q <= 1'b1;
            host_target_expired_q <= 1'b0;
            card_target_a_expired_q <= 1'b0;
            card_target_b_expired_q <= 1'b0;
            ring_output_enable_q <= 1'b0;
            video_port_hiz_enable_q <= 1'b0;
            card_rsvd5_q <= 1'b0;
            card_audio_route_en_q <= 1'b0;
            speaker_route_enable_q <= 1'b0;
            card_func_irq_flag_q <= 1'b0;
            rdata_q <= 8'h00;
            hit_q <= 1'b0;
        end else begin
            host_side_retry_counter_en_q <= host_side_retry_counter_en_d;
            card_side_retry_counter_en_q <= card_side_retry_counter_en_d;
            host_target_expired_q <= host_target_expired_d;
            card_target_a_expired_q <= card_target_a_expired_d;
            card_target_b_expired_q <= card_target_b_expired_d;
            ring_output_enable_q <= ring_output_enable_d;
            video_port_hiz_enable_q <= video_port_hiz_enable_d;
            card_rsvd5_q <= card_rsvd5_d;
            card_audio_route_en_q <= card_audio_route_en_d;
            speaker_route_enable_q <= speaker_route_enable_d;
            card_func_irq_flag_q <= card_func_irq_flag_d;
            rdata_q <= rdata_d;
            hit_q <= hit_d;
        end
    end

    // ----------------------------------------------------------------
    // Pin routing
    // ----------------------------------------------------------------
    // Routed signals are registered so every output comes from a flop;
    // this costs one clock of latency on the ring, audio, speaker and video paths.
    logic ring_pme_q, ring_pme_d;
    logic ring_multi_q, ring_multi_d;
    logic audio_q, audio_d;
    logic card_speaker_in_q, card_speaker_in_d;
    logic card_speaker_in_oe_q, card_speaker_in_oe_d;
    logic video_oe_q, video_oe_d;

    // Gate each routed signal by its control bit
    // The multi-pin copy ignores the select; the terminal mux picks the pin
    always_comb begin
        ring_pme_d = ring_output_enable_q && !ring_pin_select_i && ring_indicate_in_i;
        ring_multi_d = ring_output_enable_q && ring_indicate_in_i;
        audio_d = card_audio_route_en_q && card_audio_in_i;
        card_speaker_in_d = speaker_route_enable_q && card_speaker_in_i;
        card_speaker_in_oe_d = speaker_route_enable_q;
        video_oe_d = !video_port_hiz_enable_q;
    end

    // Pin register stage; video enable idles high so the pins drive after reset
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            ring_pme_q <= 1'b0;
            ring_multi_q <= 1'b0;
            audio_q <= 1'b0;
            card_speaker_in_q <= 1'b0;
            card_speaker_in_oe_q <= 1'b0;
            video_oe_q <= 1'b1;
        end else begin
            ring_pme_q <= ring_pme_d;
            ring_multi_q <= ring_multi_d;
            audio_q <= audio_d;
            card_speaker_in_q <= card_speaker_in_d;
            card_speaker_in_oe_q <= card_speaker_in_oe_d;
            video_oe_q <= video_oe_d;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------

    // Every output is a flop or a bit-for-bit image of flops
    assign ring_pme_pin_o = ring_pme_q;
    assign ring_multi_o = ring_multi_q;
    assign audio_pwm_output_o = audio_q;
    assign speaker_output_pin_o = card_speaker_in_q;
    assign speaker_output_pin_oe_o = card_speaker_in_oe_q;
    assign video_port_oe_o = video_oe_q;
    assign cfg_rdata_o = rdata_q;
    assign cfg_hit_o = hit_q;
    assign retry_timeout_status_o = retry_img;
    assign card_control_o = card_img;

endmodule

//--- verif/rscc_master_model.sv
// Behavioural retrying bus master for one retry channel of the bridge.
// Assumes the bench pulses go_i for one cycle just after a clock edge.
`timescale 1ns/1ps

module rscc_master_model
    import rscc_pkg::*;
(
    // Clock and reset
    input wire logic clock_i,
    input wire logic rst_i,
    // Bench command: retry now, return after so many cycles, zero never
    input wire logic go_i,
    input wire logic [7:0] back_after_i,
    // Events toward the bridge
    output rscc_retry_s ev_o
);
    logic [7:0] cnt_q;
    logic wait_q;

    // Retry pulse on go, then the return pulse once the delay runs out
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            ev_o <= '0;
            cnt_q <= 8'h00;
            wait_q <= 1'b0;
        end else begin
            ev_o.start <= go_i;
            ev_o.done <= !go_i && wait_q && back_after_i != 8'h00 && cnt_q == back_after_i;
            if (go_i) begin
                wait_q <= 1'b1;
                cnt_q <= 8'h01;
            end else if (wait_q && back_after_i != 8'h00 && cnt_q == back_after_i) begin
                // One return per retry; no stray pulse once the counter wraps
                wait_q <= 1'b0;
            end else if (wait_q) begin
                cnt_q <= cnt_q + 8'h01;
            end
        end
    end
endmodule

//--- verif/rscc_top_asserts.sv
// Concurrent checks on the retry status and card control block ports.
// Assumes binding to rscc_top with the same timeout parameter.
`timescale 1ns/1ps
`include "rscc_regs.svh"

module rscc_top_asserts
    import rscc_pkg::*;
#(
    parameter int RETRY_LOG2 = 15
) (
    // Clock and reset
    input wire logic clock_i,
    input wire logic rst_i,
    // Configuration access
    input rscc_cfg_s cfg_i,
    input wire logic [7:0] cfg_rdata_o,
    input wire logic cfg_hit_o,
    // Events and card signals
    input rscc_retry_s host_retry_i,
    input wire logic card_func_irq_i,
    input wire logic ring_indicate_in_i,
    input wire logic ring_pin_select_i,
    input wire logic card_audio_in_i,
    input wire logic card_speaker_in_i,
    // Routed outputs and images
    input wire logic ring_pme_pin_o,
    input wire logic ring_multi_o,
    input wire logic audio_pwm_output_o,
    input wire logic speaker_output_pin_o,
    input wire logic speaker_output_pin_oe_o,
    input wire logic video_port_oe_o,
    input wire logic [7:0] retry_timeout_status_o,
    input wire logic [7:0] card_control_o
);
    localparam int TMO = 1 << RETRY_LOG2;
    logic run_q, run_d;
    int cnt_q, cnt_d;

    // ------------------------------------------------
    // Shadow of the host retry wait
    // ------------------------------------------------
    // Saturates so that a long idle spell never wraps into a false alarm
    always_comb begin
        run_d = run_q;
        cnt_d = cnt_q;
        if (!retry_timeout_status_o[7] || host_retry_i.done) begin
            run_d = 1'b0;
            cnt_d = 0;
        end else if (host_retry_i.start && (!run_q || cnt_q > TMO)) begin
            run_d = 1'b1;
            cnt_d = 1;
        end else if (run_q && cnt_q < TMO + 5) begin
            cnt_d = cnt_q + 1;
        end
    end

    // Register the shadow
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            run_q <= 1'b0;
            cnt_q <= 0;
        end else begin
            run_q <= run_d;
            cnt_q <= cnt_d;
        end
    end

    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (rst_i);

    rsvd_retry_a: assert property ((retry_timeout_status_o & 8'h15) == 8'h00)
        else $error("retry reserved bits not zero");
    rsvd_card_a: assert property (card_control_o[4:3] == 2'b00)
        else $error("card reserved bits not zero");
    ring_route_a: assert property (1'b1 |=>
        ring_pme_pin_o == $past(card_control_o[7] && !ring_pin_select_i && ring_indicate_in_i)
        && ring_multi_o == $past(card_control_o[7] && ring_indicate_in_i))
        else $error("ring routing wrong");
    video_hiz_a: assert property (1'b1 |=> video_port_oe_o == !$past(card_control_o[6]))
        else $error("video port enable wrong");
    audio_route_a: assert property (1'b1 |=>
        audio_pwm_output_o == $past(card_control_o[2] && card_audio_in_i))
        else $error("audio routing wrong");
    speaker_route_a: assert property (1'b1 |=>
        speaker_output_pin_oe_o == $past(card_control_o[1])
        && speaker_output_pin_o == $past(card_control_o[1] && card_speaker_in_i))
        else $error("speaker routing wrong");
    irq_set_a: assert property (card_func_irq_i |=> card_control_o[0])
        else $error("interrupt flag not set");
    flag_hold_a: assert property (retry_timeout_status_o[1] && !(cfg_i.wr
        && cfg_i.addr == `RSCC_RETRY_OFS && cfg_i.wdata[1]) |=> retry_timeout_status_o[1])
        else $error("host expiry flag lost");
    read_data_a: assert property (cfg_i.rd && cfg_i.addr == `RSCC_RETRY_OFS |=>
        cfg_hit_o && cfg_rdata_o == $past(retry_timeout_status_o))
        else $error("retry read wrong");
    host_early_a: assert property ($rose(retry_timeout_status_o[1]) |-> cnt_q >= TMO)
        else $error("host expiry too early");
    host_late_a: assert property (cnt_q == TMO + 4 |-> retry_timeout_status_o[1])
        else $error("host expiry missing");

    cover property ($rose(retry_timeout_status_o[1]));
    cover property ($rose(retry_timeout_status_o[5]) && retry_timeout_status_o[3]);
    cover property (card_func_irq_i && cfg_i.wr);
endmodule

bind rscc_top rscc_top_asserts #(.RETRY_LOG2(RETRY_LOG2)) i_rscc_top_asserts (
    .clock_i(clock_i), .rst_i(rst_i), .cfg_i(cfg_i), .cfg_rdata_o(cfg_rdata_o),
    .cfg_hit_o(cfg_hit_o), .host_retry_i(host_retry_i), .card_func_irq_i(card_func_irq_i),
    .ring_indicate_in_i(ring_indicate_in_i), .ring_pin_select_i(ring_pin_select_i),
    .card_audio_in_i(card_audio_in_i), .card_speaker_in_i(card_speaker_in_i),
    .ring_pme_pin_o(ring_pme_pin_o), .ring_multi_o(ring_multi_o),
    .audio_pwm_output_o(audio_pwm_output_o), .speaker_output_pin_o(speaker_output_pin_o),
    .speaker_output_pin_oe_o(speaker_output_pin_oe_o), .video_port_oe_o(video_port_oe_o),
    .retry_timeout_status_o(retry_timeout_status_o), .card_control_o(card_control_o));

//--- verif/tb_top.sv
// Self-checking bench for the retry status and card control block.
// Assumes one master model per retry channel and a shortened timeout.
`timescale 1ns/1ps
`include "rscc_regs.svh"

module tb_top
    import rscc_pkg::*;
;
    localparam int L = 4;
    localparam int TMO = 1 << L;
    logic clock_i, rst_i, hit, irq, ring, sel, aud, spk, pme, multi, apwm, spk_o, spk_oe, vid_oe;
    logic [2:0] go;
    logic [7:0] rdata, back_h, back_c, rimg, cimg;
    rscc_cfg_s cfg;
    rscc_retry_s ev_h, ev_a, ev_b;
    int mismatches = 0;
    int checks_done = 0;

    rscc_top #(.RETRY_LOG2(L)) i_rscc_top (.clock_i(clock_i), .rst_i(rst_i), .cfg_i(cfg),
        .cfg_rdata_o(rdata), .cfg_hit_o(hit), .host_retry_i(ev_h), .card_a_retry_i(ev_a),
        .card_b_retry_i(ev_b), .card_func_irq_i(irq), .ring_indicate_in_i(ring),
        .ring_pin_select_i(sel), .card_audio_in_i(aud), .card_speaker_in_i(spk),
        .ring_pme_pin_o(pme), .ring_multi_o(multi), .audio_pwm_output_o(apwm),
        .speaker_output_pin_o(spk_o), .speaker_output_pin_oe_o(spk_oe),
        .video_port_oe_o(vid_oe), .retry_timeout_status_o(rimg), .card_control_o(cimg));
    rscc_master_model i_rscc_master_model_h (.clock_i(clock_i), .rst_i(rst_i), .go_i(go[0]),
        .back_after_i(back_h), .ev_o(ev_h));
    rscc_master_model i_rscc_master_model_a (.clock_i(clock_i), .rst_i(rst_i), .go_i(go[1]),
        .back_after_i(back_c), .ev_o(ev_a));
    rscc_master_model i_rscc_master_model_b (.clock_i(clock_i), .rst_i(rst_i), .go_i(go[2]),
        .back_after_i(back_c), .ev_o(ev_b));

    // ------------------------------------------------
    // Tasks
    // ------------------------------------------------
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clock_i);
        #1;
    endtask

    // One-cycle access; effect and read data are settled when it returns
    task automatic acc(input logic wr, input logic [7:0] a, input logic [7:0] d);
        cyc(1);
        cfg.rd = !wr;
        cfg.wr = wr;
        cfg.addr = a;
        cfg.wdata = d;
        cyc(1);
        cfg.rd = 1'b0;
        cfg.wr = 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input logic h);
        acc(1'b0, a, 8'h00);
        chk("read data", exp, rdata);
        chk("read hit", {7'h00, h}, {7'h00, hit});
        if (h) begin
            chk("register image", exp, (a == `RSCC_RETRY_OFS) ? rimg : cimg);
        end
    endtask

    // Retry the chosen masters; host and card masters return after their delays
    task automatic issue(input logic [2:0] g, input logic [7:0] bh, input logic [7:0] bc);
        back_h = bh;
        back_c = bc;
        go = g;
        cyc(1);
        go = 3'b000;
    endtask

    // Walk every combination of the four routed card inputs under one control byte
    task automatic route(input logic [7:0] c);
        for (int i = 0; i < 16; i++) begin
            {ring, sel, aud, spk} = i[3:0];
            cyc(2);
            chk("routing", {2'b00, c[7] & ~sel & ring, c[7] & ring, c[2] & aud,
                c[1] & spk, c[1], ~c[6]}, {2'b00, pme, multi, apwm, spk_o, spk_oe, vid_oe});
        end
    endtask

    task automatic tdone(input string name);
        $display("test %s finished", name);
    endtask

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // ------------------------------------------------
    // Clock, watchdog and test sequence
    // ------------------------------------------------
    initial begin
        clock_i = 1'b0;
        forever #5 clock_i = ~clock_i;
    end

    // The whole run needs well under ten microseconds
    initial begin
        #50000;
        mismatches++;
        $display("watchdog expired");
        end_of_test();
    end

    initial begin
        rst_i = 1'b1;
        cfg = '0;
        go = 3'b000;
        back_h = 8'h00;
        back_c = 8'h00;
        {irq, ring, sel, aud, spk} = 5'b00000;
        cyc(5);
        rst_i = 1'b0;
        rd(`RSCC_RETRY_OFS, `RSCC_RETRY_RST, 1'b1);
        rd(`RSCC_CARD_OFS, `RSCC_CARD_RST, 1'b1);
        rd(8'h92, 8'h00, 1'b0);
        tdone("reset");
        acc(1'b1, `RSCC_RETRY_OFS, 8'hff);
        rd(`RSCC_RETRY_OFS, 8'hc0, 1'b1);
        acc(1'b1, `RSCC_RETRY_OFS, 8'h3f);
        rd(`RSCC_RETRY_OFS, 8'h00, 1'b1);
        acc(1'b1, `RSCC_CARD_OFS, 8'hdf);
        rd(`RSCC_CARD_OFS, 8'hc6, 1'b1);
        route(8'hc6);
        acc(1'b1, `RSCC_CARD_OFS, 8'h00);
        route(8'h00);
        tdone("access and routing");
        issue(3'b111, 8'h00, 8'h00);
        cyc(TMO + 8);
        rd(`RSCC_RETRY_OFS, 8'h00, 1'b1);
        acc(1'b1, `RSCC_RETRY_OFS, 8'hc0);
        issue(3'b111, 8'(TMO / 2), 8'h00);
        cyc(TMO + 8);
        rd(`RSCC_RETRY_OFS, 8'he8, 1'b1);
        acc(1'b1, `RSCC_RETRY_OFS, 8'hc0);
        rd(`RSCC_RETRY_OFS, 8'he8, 1'b1);
        acc(1'b1, `RSCC_RETRY_OFS, 8'hea);
        rd(`RSCC_RETRY_OFS, 8'hc0, 1'b1);
        acc(1'b1, `RSCC_RETRY_OFS, 8'h80);
        issue(3'b111, 8'h00, 8'h00);
        cyc(TMO + 8);
        rd(`RSCC_RETRY_OFS, 8'h82, 1'b1);
        acc(1'b1, `RSCC_RETRY_OFS, 8'hc2);
        rd(`RSCC_RETRY_OFS, 8'hc0, 1'b1);
        issue(3'b001, 8'h00, 8'h00);
        cyc(TMO / 2);
        acc(1'b1, `RSCC_RETRY_OFS, 8'h40);
        acc(1'b1, `RSCC_RETRY_OFS, 8'hc0);
        cyc(TMO + 8);
        rd(`RSCC_RETRY_OFS, 8'hc0, 1'b1);
        tdone("retry timeout");
        irq = 1'b1;
        cyc(1);
        irq = 1'b0;
        rd(`RSCC_CARD_OFS, 8'h01, 1'b1);
        acc(1'b1, `RSCC_CARD_OFS, 8'h00);
        rd(`RSCC_CARD_OFS, 8'h01, 1'b1);
        irq = 1'b1;
        acc(1'b1, `RSCC_CARD_OFS, 8'h01);
        rd(`RSCC_CARD_OFS, 8'h01, 1'b1);
        irq = 1'b0;
        acc(1'b1, `RSCC_CARD_OFS, 8'h01);
        rd(`RSCC_CARD_OFS, 8'h00, 1'b1);
        tdone("interrupt flag");
        end_of_test();
    end
endmodule
